// ==== hw/ext_bus_cycles.sv ====
// external bus cycle controller with cpu-space cycles
`timescale 1ns/1ps
// Notes on behaviour
// - word reads take two bytes, byte reads one
// - word writes drive two bytes, byte writes one byte copied onto both lanes
// - fast termination completes in two clocks
// - acknowledge option 1110 selects fast termination
// - fast cycles drive address, acknowledge internally
// - fast cycles strobe data on reads only
// - space code seven marks cpu space cycles
// - address 19:16 encodes cpu cycle type
// - software breakpoint read carries number, bit1 low
// - software breakpoint ack returns instruction word
// - software breakpoint fault takes illegal instruction
// - breakpoint request reads address 00001E
// - hardware breakpoint fault takes exception, ack ignores
// - prefetch breakpoint tags instruction, flush cancels
// - operand breakpoint fires at instruction end
// - stop instruction writes mask to 3FFFE
// - stop write carries mask in bits 2:0
// - stop write acknowledged internally, fast timing
// - stop ends on reset or higher interrupt
// - external cycles take three clocks minimum; the code ends one in two clocks on an acknowledge in the first WAIT clock
module ext_bus_cycles (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // core request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_size,
  input  wire logic [23:0] req_addr,
  input  wire logic [2:0]  req_space,
  input  wire logic [15:0] req_wdata,
  input  wire logic [3:0]  req_ack_opt,
  // core instruction events
  input  wire logic        sw_brk_exec,
  input  wire logic [2:0]  sw_brk_num,
  input  wire logic        stop_exec,
  input  wire logic [2:0]  irq_level_mask,
  input  wire logic [2:0]  irq_pending_level,
  input  wire logic        prefetch_active,
  input  wire logic        operand_active,
  input  wire logic        instr_end,
  input  wire logic        pipe_flush,
  // core answers
  output logic             done_pulse,
  output logic             fault_pulse,
  output logic [15:0]      rd_data,
  output logic             brk_insert,
  output logic             illegal_exc,
  output logic             hw_brk_exc,
  output logic             low_power_halt,
  output logic [2:0]       stop_mask,
  // external bus
  output logic [23:0]      addr,
  output logic [2:0]       space_code,
  output logic [1:0]       xfer_size,
  output logic             rw_read,
  output logic             addr_strobe_n,
  output logic             data_strobe_n,
  output logic [15:0]      data_out,
  output logic             data_oe,
  input  wire logic [15:0] data_in,
  input  wire logic [1:0]  size_ack_n,
  input  wire logic        bus_fault_n,
  input  wire logic        brk_request_n
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_END  = 4'b1000
  } bus_state_t;

  typedef enum logic [2:0] {
    K_NORMAL = 3'b001,
    K_SWBRK  = 3'b010,
    K_HWBRK  = 3'b100
  } kind_t;

  bus_state_t state_reg;
  kind_t      kind_reg;
  logic       fast_reg;
  logic [1:0] cyc_cnt_reg;
  logic       stop_cyc_reg;
  logic       brk_pend_reg;
  logic       tag_reg;
  logic       op_brk_reg;
  logic       hw_fire;
  logic       ext_ack;
  logic       ext_fault;
  logic       cycle_end;
  logic       fast_done;
  logic       start;

  assign ext_ack   = (size_ack_n != 2'b11);
  assign ext_fault = ~bus_fault_n;
  // external acknowledge is not looked at in fast cycles
  assign fast_done = fast_reg && (cyc_cnt_reg == 2'(ext_bus_pkg::FAST_CYCLES - 1));
  assign cycle_end = (state_reg == ST_WAIT) &&
                     (fast_done || (!fast_reg && (ext_ack || ext_fault)));
  assign req_ready = (state_reg == ST_IDLE) && !low_power_halt && !brk_pend_reg && !sw_brk_exec && !stop_exec;
  assign start     = state_reg == ST_IDLE;

  // bus sequencer; ST_ADDR is the first clock, WAIT gives the rest
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      cyc_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cyc_cnt_reg <= 2'h0;
          if (brk_pend_reg || sw_brk_exec || (stop_exec && !low_power_halt) || (req_valid && !low_power_halt))
            state_reg <= ST_ADDR;
        end
        ST_ADDR: begin
          state_reg <= ST_WAIT;
          if (cyc_cnt_reg != 2'h3)
            cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
        end
        ST_WAIT: begin
          if (cyc_cnt_reg != 2'h3)
            cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
          if (cycle_end)
            state_reg <= ST_END;
        end
        ST_END: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // address phase: priority hardware break, software break, stop, request
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      addr         <= 24'h00_0000;
      space_code   <= 3'h0;
      xfer_size    <= 2'h0;
      rw_read      <= 1'b1;
      data_out     <= 16'h0000;
      kind_reg     <= K_NORMAL;
      fast_reg     <= 1'b0;
      stop_cyc_reg <= 1'b0;
    end else if (start) begin
      if (brk_pend_reg) begin
        addr       <= ext_bus_pkg::HW_BRK_ADDR;
        space_code <= ext_bus_pkg::SPACE_CPU;
        xfer_size  <= ext_bus_pkg::SIZE_WORD;
        rw_read    <= 1'b1;
        kind_reg   <= K_HWBRK;
        fast_reg   <= 1'b0;
        stop_cyc_reg <= 1'b0;
      end else if (sw_brk_exec) begin
        addr       <= {4'h0, ext_bus_pkg::CPU_TYPE_BRK, 11'h000, sw_brk_num, 2'b00};
        space_code <= ext_bus_pkg::SPACE_CPU;
        xfer_size  <= ext_bus_pkg::SIZE_WORD;
        rw_read    <= 1'b1;
        kind_reg   <= K_SWBRK;
        fast_reg   <= 1'b0;
        stop_cyc_reg <= 1'b0;
      end else if (stop_exec && !low_power_halt) begin
        addr       <= ext_bus_pkg::STOP_ADDR;
        space_code <= ext_bus_pkg::SPACE_CPU;
        xfer_size  <= ext_bus_pkg::SIZE_WORD;
        rw_read    <= 1'b0;
        data_out   <= {13'h0000, irq_level_mask};
        kind_reg   <= K_NORMAL;
        fast_reg   <= 1'b1;
        stop_cyc_reg <= 1'b1;
      end else if (req_valid && !low_power_halt) begin
        addr       <= req_addr;
        space_code <= req_space;
        xfer_size  <= req_size;
        rw_read    <= !req_write;
        // byte write replicates onto both lanes so either port width sees it
        data_out   <= (req_size == ext_bus_pkg::SIZE_BYTE) ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata;
        kind_reg   <= K_NORMAL;
        fast_reg   <= (req_ack_opt == ext_bus_pkg::ACK_OPT_FAST);
        stop_cyc_reg <= 1'b0;
      end
    end
  end

  // strobes: data strobe held off for fast writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      addr_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      data_oe       <= 1'b0;
    end else begin
      addr_strobe_n <= !((state_reg == ST_ADDR) || (state_reg == ST_WAIT && !cycle_end));
      data_strobe_n <= !(((state_reg == ST_ADDR) || (state_reg == ST_WAIT && !cycle_end)) &&
                         (rw_read || !fast_reg));
      data_oe       <= (state_reg == ST_ADDR || state_reg == ST_WAIT) && !rw_read && !cycle_end;
    end
  end

  // read data capture and lane steering
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 16'h0000;
    end else if (cycle_end && rw_read && !ext_fault) begin
      if (xfer_size == ext_bus_pkg::SIZE_BYTE && addr[0] && size_ack_n == 2'b01)
        rd_data <= {8'h00, data_in[7:0]};
      else if (xfer_size == ext_bus_pkg::SIZE_BYTE)
        rd_data <= {8'h00, data_in[15:8]};
      else
        rd_data <= data_in;
    end
  end

  // cycle results
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_pulse  <= 1'b0;
      fault_pulse <= 1'b0;
      brk_insert  <= 1'b0;
      illegal_exc <= 1'b0;
      hw_fire     <= 1'b0;
    end else begin
      done_pulse  <= cycle_end && kind_reg == K_NORMAL && (fast_reg || !ext_fault);
      fault_pulse <= cycle_end && kind_reg == K_NORMAL && !fast_reg && ext_fault;
      brk_insert  <= cycle_end && kind_reg == K_SWBRK && !ext_fault;
      illegal_exc <= cycle_end && kind_reg == K_SWBRK && ext_fault;
      hw_fire     <= cycle_end && kind_reg == K_HWBRK && ext_fault;
    end
  end

  // breakpoint request latch and instruction tagging
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tag_reg      <= 1'b0;
      op_brk_reg   <= 1'b0;
      brk_pend_reg <= 1'b0;
      hw_brk_exc   <= 1'b0;
    end else begin
      hw_brk_exc <= 1'b0;
      if (!brk_request_n && prefetch_active)
        tag_reg <= 1'b1;
      else if (pipe_flush)
        tag_reg <= 1'b0;
      if (!brk_request_n && operand_active)
        op_brk_reg <= 1'b1;
      if (instr_end && (tag_reg || op_brk_reg) && !brk_pend_reg) begin
        brk_pend_reg <= 1'b1;
        tag_reg      <= 1'b0;
        op_brk_reg   <= 1'b0;
      end else if (state_reg == ST_END && kind_reg == K_HWBRK) begin
        brk_pend_reg <= 1'b0;
      end
      if (hw_fire)
        hw_brk_exc <= 1'b1;
    end
  end

  // low-power stop state and wake
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      low_power_halt <= 1'b0;
      stop_mask      <= 3'h0;
    end else if (low_power_halt) begin
      if (irq_pending_level > stop_mask)
        low_power_halt <= 1'b0;
    end else if (state_reg == ST_END && stop_cyc_reg) begin
      low_power_halt <= 1'b1;
      stop_mask      <= data_out[2:0];
    end
  end

  // assertions
  property p_fast_len;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_ADDR && fast_reg) |=> (state_reg == ST_WAIT) ##1 (state_reg == ST_END);
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast cycle not two clocks");

  property p_reg_min;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_ADDR && !fast_reg) |=> !cycle_end;
  endproperty
  a_reg_min: assert property (p_reg_min) else $error("regular cycle ended too soon");

  property p_fast_ds;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_WAIT && fast_reg && !rw_read) |=> data_strobe_n;
  endproperty
  a_fast_ds: assert property (p_fast_ds) else $error("data strobe on fast write");

  property p_fast_ign;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_ADDR && fast_reg) |=> !fault_pulse [*3];
  endproperty
  a_fast_ign: assert property (p_fast_ign) else $error("fast cycle took external fault");

  property p_hw_addr;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_WAIT && kind_reg == K_HWBRK) |-> (addr == 24'h00_001E && space_code == 3'h7);
  endproperty
  a_hw_addr: assert property (p_hw_addr) else $error("bad hardware breakpoint address");

  property p_sw_addr;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_WAIT && kind_reg == K_SWBRK) |-> (addr[19:16] == 4'h0 && !addr[1] && rw_read);
  endproperty
  a_sw_addr: assert property (p_sw_addr) else $error("bad software breakpoint address");

  property p_stop_data;
    @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_WAIT && stop_cyc_reg) |-> (addr == 24'h03_FFFE && data_out[15:3] == 13'h0000);
  endproperty
  a_stop_data: assert property (p_stop_data) else $error("bad stop broadcast");

  property p_sw_fault;
    @(posedge clock) disable iff (sys_rst)
      (cycle_end && kind_reg == K_SWBRK && ext_fault) |=> illegal_exc && !brk_insert;
  endproperty
  a_sw_fault: assert property (p_sw_fault) else $error("missing illegal instruction");

  property p_hw_ack;
    @(posedge clock) disable iff (sys_rst)
      (cycle_end && kind_reg == K_HWBRK && !ext_fault) |=> ##1 !hw_brk_exc;
  endproperty
  a_hw_ack: assert property (p_hw_ack) else $error("acked breakpoint fired");

  property p_wake;
    @(posedge clock) disable iff (sys_rst)
      (low_power_halt && irq_pending_level > stop_mask) |=> !low_power_halt;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");

  c_fast: cover property (@(posedge clock) state_reg == ST_ADDR && fast_reg);
  c_hw: cover property (@(posedge clock) hw_brk_exc);
  c_stop: cover property (@(posedge clock) $rose(low_power_halt));
  c_wait: cover property (@(posedge clock) state_reg == ST_WAIT && !fast_reg && !cycle_end);

endmodule : ext_bus_cycles

// ==== hw/ext_bus_pkg.sv ====
// constants for the external bus cycle controller
package ext_bus_pkg;
  localparam logic [1:0]  SIZE_BYTE     = 2'h1;
  localparam logic [1:0]  SIZE_WORD     = 2'h2;
  localparam logic [2:0]  SPACE_CPU     = 3'h7;
  localparam logic [3:0]  CPU_TYPE_BRK  = 4'h0;
  localparam logic [3:0]  CPU_TYPE_STOP = 4'h3;
  localparam logic [3:0]  CPU_TYPE_IACK = 4'hF;
  localparam logic [3:0]  ACK_OPT_FAST  = 4'hE;
  localparam logic [23:0] HW_BRK_ADDR   = 24'h00_001E;
  localparam logic [23:0] STOP_ADDR     = 24'h03_FFFE;
  localparam logic [2:0]  HW_BRK_NUM    = 3'h7;
  localparam int          FAST_CYCLES   = 2;
  localparam int          REG_MIN_CYC   = 3;
  localparam logic [7:0]  BYTE_IDLE     = 8'hFF;
endpackage : ext_bus_pkg

// ==== verif/bus_responder.sv ====
// far-side memory and breakpoint responder for the bus controller
`timescale 1ns/1ps
module bus_responder (
  // clock and bus from the controller
  input  wire logic        clock,
  input  wire logic        addr_strobe_n,
  input  wire logic        rw_read,
  input  wire logic [23:0] addr,
  // bench control
  input  wire logic [3:0]  delay,
  input  wire logic        fault_en,
  // answers
  output logic [15:0]      data_in,
  output logic [1:0]       size_ack_n,
  output logic             bus_fault_n
);
  logic [3:0] cnt;
  initial begin
    data_in = 16'h0000;
    size_ack_n = 2'b11;
    bus_fault_n = 1'b1;
    cnt = 4'h0;
  end
  // acknowledge lines have pull-ups
  always @(posedge clock) begin
    if (addr_strobe_n) begin
      cnt <= 4'h0;
      size_ack_n <= 2'b11;
      bus_fault_n <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
      if (cnt >= delay && !fault_en) size_ack_n <= 2'b01;
      if (cnt >= delay && fault_en) bus_fault_n <= 1'b0;
    end
  end
  // fast device: read data stands by the falling edge inside the strobe,
  // otherwise the bus toggles so stale data never matches
  always @(negedge clock) begin
    if (!addr_strobe_n && rw_read) data_in <= {addr[7:0] ^ 8'h5A, addr[7:0]};
    else data_in <= ~data_in;
  end
endmodule : bus_responder

// ==== verif/ext_bus_cycles_tb.sv ====
// self-checking bench for the external bus cycle controller
`timescale 1ns/1ps
module ext_bus_cycles_tb;
  typedef struct packed {logic wr; logic [1:0] sz; logic [23:0] ad; logic [15:0] wd;
                         logic fast; logic flt; logic [15:0] ex; logic ds;} row_t;
  logic        clock = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic        sw_brk_exec = 1'b0, stop_exec = 1'b0, prefetch_active = 1'b0, operand_active = 1'b0;
  logic        instr_end = 1'b0, pipe_flush = 1'b0, brk_request_n = 1'b1, flt = 1'b0;
  logic [1:0]  req_size = 2'h2, xfer_size, size_ack_n, msz;
  logic [23:0] req_addr = 24'h00_0000, addr, ma;
  logic [2:0]  req_space = 3'h5, sw_brk_num = 3'h0, irq_level_mask = 3'h0, irq_pending_level = 3'h0;
  logic [2:0]  space_code, stop_mask, msp;
  logic [15:0] req_wdata = 16'h0000, rd_data, data_out, data_in, mdo;
  logic [3:0]  req_ack_opt = 4'hF, dly = 4'h0;
  logic        req_ready, done_pulse, fault_pulse, brk_insert, illegal_exc, hw_brk_exc, low_power_halt;
  logic        rw_read, addr_strobe_n, data_strobe_n, data_oe, bus_fault_n;
  logic        sd, sf, si, sl, sh, mas, mds, moe;
  int          error_cnt = 0, checks = 0, k, k0;
  row_t        rows[7] = '{
    '{1'b0, ext_bus_pkg::SIZE_WORD, 24'h00_1000, 16'h0000, 1'b0, 1'b0, 16'h5A00, 1'b1},
    '{1'b0, ext_bus_pkg::SIZE_BYTE, 24'h00_1001, 16'h0000, 1'b0, 1'b0, 16'h0001, 1'b1},
    '{1'b0, ext_bus_pkg::SIZE_BYTE, 24'h00_1002, 16'h0000, 1'b1, 1'b1, 16'h0058, 1'b1},
    '{1'b0, ext_bus_pkg::SIZE_WORD, 24'h00_1004, 16'h0000, 1'b1, 1'b0, 16'h5E04, 1'b1},
    '{1'b1, ext_bus_pkg::SIZE_WORD, 24'h00_2000, 16'h1234, 1'b0, 1'b0, 16'h1234, 1'b1},
    '{1'b1, ext_bus_pkg::SIZE_BYTE, 24'h00_2001, 16'h00AB, 1'b1, 1'b0, 16'hABAB, 1'b0},
    '{1'b1, ext_bus_pkg::SIZE_WORD, 24'h00_2002, 16'hBEEF, 1'b1, 1'b1, 16'hBEEF, 1'b0}};

  ext_bus_cycles dut_u (.clock, .sys_rst, .req_valid, .req_ready, .req_write, .req_size, .req_addr, .req_space,
    .req_wdata, .req_ack_opt, .sw_brk_exec, .sw_brk_num, .stop_exec, .irq_level_mask, .irq_pending_level,
    .prefetch_active, .operand_active, .instr_end, .pipe_flush, .done_pulse, .fault_pulse, .rd_data,
    .brk_insert, .illegal_exc, .hw_brk_exc, .low_power_halt, .stop_mask, .addr, .space_code, .xfer_size,
    .rw_read, .addr_strobe_n, .data_strobe_n, .data_out, .data_oe, .data_in, .size_ack_n, .bus_fault_n,
    .brk_request_n);
  bus_responder rsp_u (.clock, .addr_strobe_n, .rw_read, .addr, .delay(dly), .fault_en(flt), .data_in,
    .size_ack_n, .bus_fault_n);

  always #2.5 clock = ~clock;
  // sticky record of pulses and of what the bus showed while the address strobe was low
  always @(posedge clock) begin
    if (done_pulse) sd <= 1'b1;
    if (fault_pulse) sf <= 1'b1;
    if (brk_insert) si <= 1'b1;
    if (illegal_exc) sl <= 1'b1;
    if (hw_brk_exc) sh <= 1'b1;
    if (!data_strobe_n) mds <= 1'b1;
    if (data_oe) moe <= 1'b1;
    if (!addr_strobe_n) begin
      mas <= 1'b1;
      ma <= addr;
      msp <= space_code;
      msz <= xfer_size;
      mdo <= data_out;
    end
  end

  task close_out;
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task chk_v(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v
  task chk_b(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b
  task tick;
    @(posedge clock);
    #1;
  endtask : tick
  task clr;
    {sd, sf, si, sl, sh, mas, mds, moe} = 8'h00;
  endtask : clr
  // bounded wait for the first answer or a finished silent cycle, then let late pulses land
  task wait_end;
    k = 0;
    while (!(done_pulse | fault_pulse | brk_insert | illegal_exc | hw_brk_exc | low_power_halt |
             (mas & req_ready))) begin
      tick;
      k++;
      if (k > 60) begin
        error_cnt++;
        close_out;
      end
    end
    repeat (3) tick;
  endtask : wait_end
  task req(input logic wr, input logic [1:0] sz, input logic [23:0] ad, input logic [15:0] wd, input logic [3:0] o);
    clr;
    {req_write, req_size, req_addr, req_wdata, req_ack_opt} = {wr, sz, ad, wd, o};
    req_valid = 1'b1;
    tick;
    req_valid = 1'b0;
    wait_end;
  endtask : req
  task stop_go(input logic [2:0] m);
    irq_level_mask = m;
    clr;
    stop_exec = 1'b1;
    tick;
    stop_exec = 1'b0;
    wait_end;
    chk_v(ma, ext_bus_pkg::STOP_ADDR);
    chk_v(msp, ext_bus_pkg::SPACE_CPU);
    chk_v(mdo, {21'h00_0000, m});
    chk_b(mds, 1'b0);
    chk_v(stop_mask, m);
    chk_b(low_power_halt, 1'b1);
    chk_b(req_ready, 1'b0);
  endtask : stop_go
  task rst_chk;
    chk_b(addr_strobe_n & data_strobe_n & rw_read, 1'b1);
    chk_b(data_oe | low_power_halt, 1'b0);
    chk_v(addr, 24'h00_0000);
  endtask : rst_chk

  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst_chk;
    sys_rst = 1'b0;
    tick;
    // two of the fast rows also see an external fault, which must be ignored
    foreach (rows[j]) begin
      flt = rows[j].flt;
      req(rows[j].wr, rows[j].sz, rows[j].ad, rows[j].wd, rows[j].fast ? ext_bus_pkg::ACK_OPT_FAST : 4'hF);
      chk_b(sd & !sf, 1'b1);
      chk_v(rows[j].wr ? mdo : rd_data, rows[j].ex);
      chk_v(ma, rows[j].ad);
      chk_v(msz, rows[j].sz);
      chk_b(mds, rows[j].ds);
      chk_b(moe, rows[j].wr);
      chk_v(msp, 24'h00_0005);
      if (rows[j].fast) chk_v(24'(k), 24'(ext_bus_pkg::FAST_CYCLES));
      else chk_b(k >= 3, 1'b1);
    end
    flt = 1'b0;
    req(1'b0, ext_bus_pkg::SIZE_WORD, 24'h00_1000, 16'h0000, 4'hF);
    k0 = k;
    dly = 4'h4;
    req(1'b0, ext_bus_pkg::SIZE_WORD, 24'h00_1000, 16'h0000, 4'hF);
    chk_v(24'(k), 24'(k0 + 4));
    flt = 1'b1;
    req(1'b0, ext_bus_pkg::SIZE_WORD, 24'h00_1000, 16'h0000, 4'hF);
    chk_b(sf & !sd, 1'b1);
    dly = 4'h0;
    for (int f = 0; f < 2; f++) begin
      flt = f[0];
      clr;
      sw_brk_num = 3'h5;
      sw_brk_exec = 1'b1;
      tick;
      sw_brk_exec = 1'b0;
      wait_end;
      chk_v(ma, 24'h00_0014);
      chk_v(msp, ext_bus_pkg::SPACE_CPU);
      chk_b(si, !f[0]);
      chk_b(sl, f[0]);
      if (f == 0) chk_v(rd_data, 16'h4E14);
    end
    for (int m = 0; m < 4; m++) begin
      flt = m[0];
      clr;
      brk_request_n = 1'b0;
      prefetch_active = m[1];
      operand_active = !m[1];
      tick;
      {brk_request_n, prefetch_active, operand_active, instr_end} = 4'b1001;
      tick;
      instr_end = 1'b0;
      wait_end;
      chk_v(ma, ext_bus_pkg::HW_BRK_ADDR);
      chk_v(msp, ext_bus_pkg::SPACE_CPU);
      chk_b(sh, m[0]);
    end
    clr;
    {brk_request_n, prefetch_active} = 2'b01;
    tick;
    {brk_request_n, prefetch_active, pipe_flush} = 3'b101;
    tick;
    {pipe_flush, instr_end} = 2'b01;
    tick;
    instr_end = 1'b0;
    repeat (10) tick;
    chk_b(mas | sh, 1'b0);
    stop_go(3'h3);
    irq_pending_level = 3'h3;
    repeat (4) tick;
    chk_b(low_power_halt, 1'b1);
    irq_pending_level = 3'h4;
    repeat (4) tick;
    chk_b(low_power_halt, 1'b0);
    stop_go(3'h5);
    sys_rst = 1'b1;
    tick;
    rst_chk;
    sys_rst = 1'b0;
    tick;
    close_out;
  end
endmodule : ext_bus_cycles_tb
